/* File: design/rvm_pkg.sv */
// Shared constants for the regulator voltage monitor
package rvm_pkg;
    localparam int NREG = 4;
    localparam int CNT_W = 12;
    localparam int CLK_PERIOD_NS = 50;

    // Filter times in ns, low and high fault
    localparam int LOW_T0_NS = 5000;
    localparam int LOW_T1_NS = 15000;
    localparam int LOW_T2_NS = 30000;
    localparam int LOW_T3_NS = 40000;
    localparam int HIGH_T0_NS = 30000;
    localparam int HIGH_T1_NS = 50000;
    localparam int HIGH_T2_NS = 80000;
    localparam int HIGH_T3_NS = 125000;

    // Least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] LOW_C0 = CNT_W'((LOW_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW_C1 = CNT_W'((LOW_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW_C2 = CNT_W'((LOW_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW_C3 = CNT_W'((LOW_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIGH_C0 = CNT_W'((HIGH_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIGH_C1 = CNT_W'((HIGH_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIGH_C2 = CNT_W'((HIGH_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIGH_C3 = CNT_W'((HIGH_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Trip levels in percent of nominal (95, 93, 91, 89 and 105, 107, 109, 111)
    localparam logic [7:0] LOW_PCT0 = 8'h5f;
    localparam logic [7:0] LOW_PCT1 = 8'h5d;
    localparam logic [7:0] LOW_PCT2 = 8'h5b;
    localparam logic [7:0] LOW_PCT3 = 8'h59;
    localparam logic [7:0] HIGH_PCT0 = 8'h69;
    localparam logic [7:0] HIGH_PCT1 = 8'h6b;
    localparam logic [7:0] HIGH_PCT2 = 8'h6d;
    localparam logic [7:0] HIGH_PCT3 = 8'h6f;

    // Register byte addresses
    localparam logic [7:0] ADDR_FILTER = 8'h00;
    localparam logic [7:0] ADDR_SUPV_EN = 8'h04;
    localparam logic [7:0] ADDR_LIVE = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_SECURE_KEY = 8'h14;
    localparam logic [7:0] ADDR_TRIP_CODES = 8'h18;

    // Field positions and reset values
    localparam int FILT_LOW_LSB = 0;
    localparam int FILT_HIGH_LSB = 2;
    localparam int HIGH_CODE_LSB = 8;
    localparam logic [1:0] FILT_LOW_RST = 2'h2;
    localparam logic [1:0] FILT_HIGH_RST = 2'h0;
    localparam logic [NREG-1:0] SUPV_RST = 4'hf;
    localparam logic [7:0] SECURE_KEY_VAL = 8'h5a;

    // Trip code capture sequence after reset release
    localparam logic [1:0] OTP_LOAD = 2'h2;
    localparam logic [1:0] OTP_DONE = 2'h3;
endpackage : rvm_pkg

/* File: design/rvm_chan_if.sv */
// Carrier between the monitor control and one debounce channel
`timescale 1ns/1ns
`default_nettype none
interface rvm_chan_if;
    logic cond;
    logic active;
    logic [rvm_pkg::CNT_W-1:0] limit;
    logic fault;
    modport ctrl (output cond, output active, output limit, input fault);
    modport chan (input cond, input active, input limit, output fault);
endinterface : rvm_chan_if
`default_nettype wire

/* File: design/rvm_chan.sv */
// One debounce channel for a single comparator
`timescale 1ns/1ns
`default_nettype none
module rvm_chan (
    input wire logic pclk,
    input wire logic presetn,
    rvm_chan_if.chan ch
);
    import rvm_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fault;
    } rvm_chan_state_type;

    rvm_chan_state_type s;
    rvm_chan_state_type next_s;

    always_comb begin
        next_s = s;
        if (!ch.active) begin
            next_s.cnt = '0;
            next_s.fault = 1'b0;
        end else if (!ch.cond) begin
            // Any gap restarts the filter
            next_s.cnt = '0;
            next_s.fault = 1'b0;
        end else begin
            // A shorter filter chosen mid-count trips at once instead of wrapping
            if (s.cnt < ch.limit) begin
                next_s.cnt = s.cnt + 1'b1;
            end
            next_s.fault = (next_s.cnt >= ch.limit);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ch.fault = s.fault;
endmodule : rvm_chan
`default_nettype wire

/* File: design/rvm_top.sv */
// Regulator voltage monitor: control, filters and APB registers
`timescale 1ns/1ns
`default_nettype none
module rvm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic secure_write_enable,
    input wire logic [5:0] buck_low_trip_code,
    input wire logic [1:0] linear_low_trip_code,
    input wire logic [5:0] buck_high_trip_code,
    input wire logic [1:0] linear_high_trip_code,
    input wire logic [rvm_pkg::NREG-1:0] comp_low,
    input wire logic [rvm_pkg::NREG-1:0] comp_high,
    input wire logic [rvm_pkg::NREG-1:0] reg_on,
    input wire logic [rvm_pkg::NREG-1:0] reg_in_regulation,
    output logic [2:0] buck_supervision_enable,
    output logic linear_supervision_enable,
    output logic [8*rvm_pkg::NREG-1:0] low_trip_pct,
    output logic [8*rvm_pkg::NREG-1:0] high_trip_pct,
    output logic [rvm_pkg::NREG-1:0] low_fault_status,
    output logic [rvm_pkg::NREG-1:0] high_fault_status,
    output logic irq
);
    import rvm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Lookup functions

    function automatic logic [7:0] low_pct_of(input logic [1:0] code);
        case (code)
            2'h0: low_pct_of = LOW_PCT0;
            2'h1: low_pct_of = LOW_PCT1;
            2'h2: low_pct_of = LOW_PCT2;
            default: low_pct_of = LOW_PCT3;
        endcase
    endfunction : low_pct_of

    function automatic logic [7:0] high_pct_of(input logic [1:0] code);
        case (code)
            2'h0: high_pct_of = HIGH_PCT0;
            2'h1: high_pct_of = HIGH_PCT1;
            2'h2: high_pct_of = HIGH_PCT2;
            default: high_pct_of = HIGH_PCT3;
        endcase
    endfunction : high_pct_of

    function automatic logic [CNT_W-1:0] low_limit_of(input logic [1:0] sel);
        case (sel)
            2'h0: low_limit_of = LOW_C0;
            2'h1: low_limit_of = LOW_C1;
            2'h2: low_limit_of = LOW_C2;
            default: low_limit_of = LOW_C3;
        endcase
    endfunction : low_limit_of

    function automatic logic [CNT_W-1:0] high_limit_of(input logic [1:0] sel);
        case (sel)
            2'h0: high_limit_of = HIGH_C0;
            2'h1: high_limit_of = HIGH_C1;
            2'h2: high_limit_of = HIGH_C2;
            default: high_limit_of = HIGH_C3;
        endcase
    endfunction : high_limit_of

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            ADDR_FILTER, ADDR_SUPV_EN, ADDR_LIVE, ADDR_INT_STATUS,
            ADDR_INT_MASK, ADDR_SECURE_KEY, ADDR_TRIP_CODES: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [2*NREG-1:0] cmp_s1;
        logic [2*NREG-1:0] cmp_s2;
        logic [NREG-1:0] on_s1;
        logic [NREG-1:0] on_s2;
        logic [NREG-1:0] good_s1;
        logic [NREG-1:0] good_s2;
        logic [4*NREG-1:0] otp_s1;
        logic [4*NREG-1:0] otp_s2;
        logic [1:0] otp_phase;
        logic [2*NREG-1:0] low_code;
        logic [2*NREG-1:0] high_code;
        logic [8*NREG-1:0] low_pct;
        logic [8*NREG-1:0] high_pct;
        logic [NREG-1:0] armed;
        logic [1:0] filt_low;
        logic [1:0] filt_high;
        logic [NREG-1:0] supv_en;
        logic key_armed;
        logic [2*NREG-1:0] prev_fault;
        logic [2*NREG-1:0] sticky;
        logic [2*NREG-1:0] mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } rvm_state_type;

    rvm_state_type s;
    rvm_state_type next_s;
    logic [2*NREG-1:0] fault_w;

    ////////////////////////////////////////////////////////////////////////////
    // Debounce channels: low faults first, then high faults

    rvm_chan_if ch_if[2*NREG] ();

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : gen_reg
            // Masked while off, disabled, or not yet in regulation
            assign ch_if[g].active = s.supv_en[g] & s.on_s2[g] & s.armed[g];
            assign ch_if[g + NREG].active = s.supv_en[g] & s.on_s2[g] & s.armed[g];
            assign ch_if[g].cond = s.cmp_s2[g];
            assign ch_if[g + NREG].cond = s.cmp_s2[g + NREG];
            assign ch_if[g].limit = low_limit_of(s.filt_low);
            assign ch_if[g + NREG].limit = high_limit_of(s.filt_high);
            assign fault_w[g] = ch_if[g].fault;
            assign fault_w[g + NREG] = ch_if[g + NREG].fault;

            rvm_chan u_low (
                .pclk(pclk),
                .presetn(presetn),
                .ch(ch_if[g])
            );

            rvm_chan u_high (
                .pclk(pclk),
                .presetn(presetn),
                .ch(ch_if[g + NREG])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic access;
        logic done;
        logic [2*NREG-1:0] clr;
        logic [2*NREG-1:0] ev;
        logic [31:0] rd;
        access = psel & penable;
        done = access & s.pready;
        clr = '0;
        ev = '0;
        rd = '0;
        next_s = s;

        // Comparator, regulator and trip code pins pass two flops before use
        next_s.cmp_s1 = {comp_high, comp_low};
        next_s.cmp_s2 = s.cmp_s1;
        next_s.on_s1 = reg_on;
        next_s.on_s2 = s.on_s1;
        next_s.good_s1 = reg_in_regulation;
        next_s.good_s2 = s.good_s1;
        next_s.otp_s1 = {linear_high_trip_code, buck_high_trip_code,
                         linear_low_trip_code, buck_low_trip_code};
        next_s.otp_s2 = s.otp_s1;

        // Fuse codes captured once, after the synchroniser has filled
        if (s.otp_phase != OTP_DONE) begin
            next_s.otp_phase = s.otp_phase + 2'h1;
            if (s.otp_phase == OTP_LOAD) begin
                next_s.low_code = s.otp_s2[2*NREG-1:0];
                next_s.high_code = s.otp_s2[4*NREG-1:2*NREG];
            end
        end

        for (int i = 0; i < NREG; i++) begin
            next_s.low_pct[8*i +: 8] = low_pct_of(s.low_code[2*i +: 2]);
            next_s.high_pct[8*i +: 8] = high_pct_of(s.high_code[2*i +: 2]);
            // Re-arm on every turn-on so the ramp never trips
            if (!s.on_s2[i]) begin
                next_s.armed[i] = 1'b0;
            end else if (s.good_s2[i]) begin
                next_s.armed[i] = 1'b1;
            end
        end

        // Read mux
        case (paddr)
            ADDR_FILTER: begin
                rd[FILT_LOW_LSB +: 2] = s.filt_low;
                rd[FILT_HIGH_LSB +: 2] = s.filt_high;
            end
            ADDR_SUPV_EN: rd[NREG-1:0] = s.supv_en;
            ADDR_LIVE: rd[2*NREG-1:0] = fault_w;
            ADDR_INT_STATUS: rd[2*NREG-1:0] = s.sticky;
            ADDR_INT_MASK: rd[2*NREG-1:0] = s.mask;
            ADDR_TRIP_CODES: begin
                rd[2*NREG-1:0] = s.low_code;
                rd[HIGH_CODE_LSB +: 2*NREG] = s.high_code;
            end
            default: rd = '0;
        endcase

        // One wait state: answer on the second access cycle
        next_s.pready = access & ~s.pready;
        if (access && !s.pready) begin
            next_s.prdata = rd;
            next_s.pslverr = ~is_mapped(paddr);
        end

        if (done && pwrite) begin
            // Any completed write spends the secure key
            next_s.key_armed = 1'b0;
            case (paddr)
                ADDR_FILTER: begin
                    next_s.filt_low = pwdata[FILT_LOW_LSB +: 2];
                    next_s.filt_high = pwdata[FILT_HIGH_LSB +: 2];
                end
                ADDR_SUPV_EN: begin
                    if (!secure_write_enable || s.key_armed) begin
                        next_s.supv_en = pwdata[NREG-1:0];
                    end
                end
                ADDR_INT_MASK: next_s.mask = pwdata[2*NREG-1:0];
                ADDR_SECURE_KEY: next_s.key_armed = (pwdata[7:0] == SECURE_KEY_VAL);
                default: next_s.key_armed = 1'b0;
            endcase
        end

        if (done && !pwrite && paddr == ADDR_INT_STATUS) begin
            clr = '1;
        end

        // Rising status edges are events; set beats read clear
        ev = fault_w & ~s.prev_fault;
        next_s.prev_fault = fault_w;
        next_s.sticky = (s.sticky & ~clr) | ev;
        next_s.irq = |(next_s.sticky & next_s.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.filt_low <= FILT_LOW_RST;
            s.filt_high <= FILT_HIGH_RST;
            s.supv_en <= SUPV_RST;
            s.low_pct <= {NREG{LOW_PCT0}};
            s.high_pct <= {NREG{HIGH_PCT0}};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign buck_supervision_enable = s.supv_en[2:0];
    assign linear_supervision_enable = s.supv_en[NREG-1];
    assign low_trip_pct = s.low_pct;
    assign high_trip_pct = s.high_pct;
    assign low_fault_status = fault_w[NREG-1:0];
    assign high_fault_status = fault_w[2*NREG-1:NREG];
endmodule : rvm_top
`default_nettype wire

/* File: tb/rvm_reg_model.sv */
// Regulator and comparator model on the far side of the monitor
`timescale 1ns/1ns
`default_nettype none
module rvm_reg_model (
    input wire logic pclk,
    input wire logic [3:0] power_req,
    input wire logic [3:0] slow,
    input wire logic [3:0] flt_low,
    input wire logic [3:0] flt_high,
    output logic [3:0] reg_on,
    output logic [3:0] reg_in_regulation,
    output logic [3:0] comp_low,
    output logic [3:0] comp_high
);
    int ramp [4] = '{0, 0, 0, 0};
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            reg_on[i] <= power_req[i];
            reg_in_regulation[i] <= power_req[i] && ramp[i] == 0;
            if (!power_req[i]) begin
                ramp[i] <= slow[i] ? 400 : 6;
            end else if (ramp[i] != 0) begin
                ramp[i] <= ramp[i] - 1;
            end
        end
    end
    // Output sits below the low trip while off or still ramping
    assign comp_low = flt_low | ~reg_in_regulation;
    assign comp_high = flt_high;
endmodule : rvm_reg_model
`default_nettype wire

/* File: tb/rvm_top_monitor.sv */
// Concurrent checks on the regulator voltage monitor ports
`timescale 1ns/1ns
`default_nettype none
module rvm_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] buck_low_trip_code,
    input wire logic [1:0] linear_high_trip_code,
    input wire logic [3:0] comp_low,
    input wire logic [3:0] comp_high,
    input wire logic [3:0] reg_on,
    input wire logic [2:0] buck_supervision_enable,
    input wire logic linear_supervision_enable,
    input wire logic [31:0] low_trip_pct,
    input wire logic [31:0] high_trip_pct,
    input wire logic [3:0] low_fault_status,
    input wire logic [3:0] high_fault_status
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_low_pct;
        presetn [*8] |-> low_trip_pct[7:0] == 8'h5f - {5'h0, buck_low_trip_code[1:0], 1'b0};
    endproperty
    a_low_pct: assert property (p_low_pct) else $error("low trip level wrong");
    property p_high_pct;
        presetn [*8] |-> high_trip_pct[31:24] == 8'h69 + {5'h0, linear_high_trip_code, 1'b0};
    endproperty
    a_high_pct: assert property (p_high_pct) else $error("high trip level wrong");
    property p_en_reset;
        $rose(presetn) |-> buck_supervision_enable == 3'h7 && linear_supervision_enable == 1'b1;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enables not set");
    property p_off_quiet;
        (!reg_on[1]) [*5] |-> low_fault_status[1] == 1'b0 && high_fault_status[1] == 1'b0;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("status while off");
    property p_dis_clear;
        (!buck_supervision_enable[0]) [*4] |-> !low_fault_status[0] && !high_fault_status[0];
    endproperty
    a_dis_clear: assert property (p_dis_clear) else $error("status while disabled");
    property p_low_quiet;
        (!comp_low[2]) [*5] |-> low_fault_status[2] == 1'b0;
    endproperty
    a_low_quiet: assert property (p_low_quiet) else $error("low status held");
    property p_high_quiet;
        (!comp_high[3]) [*5] |-> high_fault_status[3] == 1'b0;
    endproperty
    a_high_quiet: assert property (p_high_quiet) else $error("high status held");
    // Shortest high filter is 600 cycles, so the cause is older than 300
    property p_high_min;
        $rose(high_fault_status[0]) |-> $past(comp_high[0], 300);
    endproperty
    a_high_min: assert property (p_high_min) else $error("high status too early");
endmodule : rvm_top_monitor
bind rvm_top rvm_top_monitor mon (.pclk, .presetn, .buck_low_trip_code, .linear_high_trip_code,
    .comp_low, .comp_high, .reg_on, .buck_supervision_enable, .linear_supervision_enable,
    .low_trip_pct, .high_trip_pct, .low_fault_status, .high_fault_status);
`default_nettype wire

/* File: tb/rvm_top_tb.sv */
// Testbench for the regulator voltage monitor
`timescale 1ns/1ns
`default_nettype none
module rvm_top_tb;
    import rvm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic secure_write_enable = 1'b0, pready, pslverr, irq, linear_supervision_enable, perr;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, low_trip_pct, high_trip_pct;
    logic [5:0] buck_low_trip_code, buck_high_trip_code;
    logic [1:0] linear_low_trip_code, linear_high_trip_code;
    logic [3:0] comp_low, comp_high, reg_on, reg_in_regulation, low_fault_status, high_fault_status;
    logic [3:0] pwr = 4'h0, slow = 4'h2, flo = 4'h0, fhi = 4'h0;
    logic [2:0] buck_supervision_enable;
    wire logic [7:0] lcode = {linear_low_trip_code, buck_low_trip_code};
    wire logic [7:0] hcode = {linear_high_trip_code, buck_high_trip_code};
    int num_errors = 0, cmp_count = 0, seed = 32'h7c0f534e;
    int lo_us [4] = '{5, 15, 30, 40};
    int hi_us [4] = '{30, 50, 80, 125};
    rvm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .secure_write_enable, .buck_low_trip_code, .linear_low_trip_code,
        .buck_high_trip_code, .linear_high_trip_code, .comp_low, .comp_high, .reg_on,
        .reg_in_regulation, .buck_supervision_enable, .linear_supervision_enable,
        .low_trip_pct, .high_trip_pct, .low_fault_status, .high_fault_status, .irq);
    rvm_reg_model farside (.pclk, .power_req(pwr), .slow, .flt_low(flo), .flt_high(fhi),
        .reg_on, .reg_in_regulation, .comp_low, .comp_high);
    initial begin
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Holds the request until pready is sampled high, then idles a cycle
    // Only the watchdog bounds the wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    // Raises one comparator and times the status, 20 cycles per microsecond
    task automatic trip(input int i, input logic hi, input int us);
        int cnt;
        cnt = 0;
        if (hi) begin
            fhi[i] <= 1'b1;
        end else begin
            flo[i] <= 1'b1;
        end
        do begin
            @(posedge pclk);
            cnt++;
        end while ((hi ? high_fault_status[i] : low_fault_status[i]) !== 1'b1 && cnt < 3000);
        chk(32'(cnt >= us * 20 && cnt <= us * 20 + 5), 32'h1);
    endtask : trip
    function automatic logic [31:0] pct4(input logic [7:0] c, input logic hi);
        logic [31:0] v;
        for (int k = 0; k < 4; k++) begin
            v[8*k +: 8] = hi ? 8'h69 + {5'h0, c[2*k +: 2], 1'b0} : 8'h5f - {5'h0, c[2*k +: 2], 1'b0};
        end
        return v;
    endfunction : pct4
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {buck_low_trip_code, linear_low_trip_code, buck_high_trip_code, linear_high_trip_code} <=
            16'($random(seed));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(low_trip_pct, pct4(lcode, 1'b0));
        chk(high_trip_pct, pct4(hcode, 1'b1));
        rchk(ADDR_FILTER, 32'h2);
        rchk(ADDR_SUPV_EN, 32'hf);
        rchk(ADDR_TRIP_CODES, {16'h0, hcode, lcode});
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(perr), 32'h1);
        apb(1'b1, ADDR_INT_MASK, 32'hff);
        apb(1'b1, ADDR_FILTER, 32'h0);
        pwr <= 4'hf;
        repeat (420) @(posedge pclk);
        chk({high_fault_status, low_fault_status}, 32'h0);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ADDR_FILTER, 32'(s));
            trip(s, 1'b0, lo_us[s]);
            flo[s] <= 1'b0;
            apb(1'b1, ADDR_FILTER, 32'(4 * s));
            chk(32'(irq), 32'h1);
            trip(s, 1'b1, hi_us[s]);
            fhi[s] <= 1'b0;
            rchk(ADDR_INT_STATUS, 32'h11 << s);
            rchk(ADDR_INT_STATUS, 32'h0);
            chk(32'(irq), 32'h0);
        end
        // A short gap must restart the count
        flo[2] <= 1'b1;
        repeat (20 + $unsigned($random(seed)) % 70) @(posedge pclk);
        flo[2] <= 1'b0;
        repeat (3 + $unsigned($random(seed)) % 6) @(posedge pclk);
        trip(2, 1'b0, 5);
        flo[2] <= 1'b0;
        apb(1'b1, ADDR_INT_MASK, 32'h0);
        trip(0, 1'b0, 5);
        rchk(ADDR_LIVE, 32'h1);
        apb(1'b1, ADDR_SUPV_EN, 32'he);
        repeat (3) @(posedge pclk);
        chk({irq, low_fault_status[0], linear_supervision_enable, buck_supervision_enable}, 32'he);
        rchk(ADDR_LIVE, 32'h0);
        rchk(ADDR_INT_STATUS, 32'h5);
        secure_write_enable <= 1'b1;
        apb(1'b1, ADDR_SUPV_EN, 32'hf);
        rchk(ADDR_SUPV_EN, 32'he);
        apb(1'b1, ADDR_SECURE_KEY, {24'h0, SECURE_KEY_VAL});
        apb(1'b1, ADDR_SUPV_EN, 32'hf);
        rchk(ADDR_SUPV_EN, 32'hf);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        finish_test();
    end
endmodule : rvm_top_tb
`default_nettype wire
